// ### src/npe_engine.sv
// nand page ecc engine: flash bus snooper, code checker and ahb-lite register slave
// How it works
// - page length select in mode register picks 512/1024/2048/4096-word main areas.
// - a 00h read or 80h program command starts a new computation.
// - results become valid at main area end and stay locked until restart; on reads the spare check then sets status and may load parity.
// - zero syndrome reports no error and sets no flag.
// - single data error sets only correctable flag, with word and bit location.
// - single error inside the stored code sets the stored code error flag.
// - any other nonzero syndrome sets the multiple error flag.
// - status and both parity registers clear on start command or software reset.
// - a 32-bit single correct double detect code covers 512 to 4096 words.
// - sixteen bits per side: line parity above, column parity below.
// - column parity taps data bits by their bit index, true and inverted.
// - highest line term grows with the main area size.
// - single bit errors are located, double errors are only flagged.
// - registers sit behind a standard peripheral bus slave.
// - words are 8 or 16 bits; main area precedes the spare area.
//
// Chosen here: register access over AHB-Lite and the register offsets.
`default_nettype none
module npe_engine import npe_pkg::*; (
  input  wire logic                 i_core_clk,
  input  wire logic                 i_nrst,
  // ahb-lite slave
  input  wire logic                 i_hsel,
  input  wire logic [31:0]          i_haddr,
  input  wire logic [1:0]           i_htrans,
  input  wire logic                 i_hwrite,
  input  wire logic [2:0]           i_hsize,
  input  wire logic [31:0]          i_hwdata,
  input  wire logic                 i_hready,
  output logic                      o_hreadyout,
  output logic                      o_hresp,
  output logic      [31:0]          o_hrdata,
  // external bus cycles towards the flash, snooped on the core clock
  input  wire npe_nf_t              i_nf,
  input  wire logic                 i_nf_wide,
  // interrupt
  output logic                      o_irq
);
  typedef struct packed {
    // bus side
    logic                   ph_valid;
    logic                   ph_write;
    logic                   ph_hit;
    logic [NPE_OFS_W-1:0]   ph_ofs;
    logic                   rd_wait;
    logic [31:0]            hrdata;
    // software visible
    logic [NPE_SEL_W-1:0]   page_sel;
    logic [NPE_ST_W-1:0]    status;
    logic [NPE_LOC_W-1:0]   parity;
    logic [NPE_CODE_W-1:0]  nparity;
    logic [NPE_IRQ_W-1:0]   irq_stat;
    logic [NPE_IRQ_W-1:0]   irq_en;
    // page walker
    npe_fsm_t               fsm;
    logic                   is_read;
    logic [NPE_WORD_W-1:0]  word_cnt;
    logic [1:0]             spare_cnt;
    logic [NPE_CODE_W-1:0]  acc_p;
    logic [NPE_CODE_W-1:0]  acc_n;
    logic [31:0]            stored;
  } npe_state_t;

  npe_state_t st_r;
  npe_state_t st_nxt;

  logic [NPE_CODE_W-1:0] word_p;
  logic [NPE_CODE_W-1:0] word_n;
  logic [NPE_CODE_W-1:0] code_mask;
  logic [NPE_CODE_W-1:0] acc_p_nxt;
  logic [NPE_CODE_W-1:0] acc_n_nxt;
  logic                  is_start;
  logic                  main_last;
  logic                  spare_last;
  logic                  take;
  logic                  bus_wr;
  logic                  sw_reset;
  logic [NPE_IRQ_W-1:0]  irq_set;

  // per-word parity of the word on the flash bus at the current offset
  npe_word_parity u_word_parity (
    .i_data (i_nf.data),
    .i_word (st_r.word_cnt),
    .i_wide (i_nf_wide),
    .o_par  (word_p),
    .o_npar (word_n)
  );

  // a word that is the only set bit, used to spot a lone bad code bit
  function automatic logic npe_one_hot(input logic [NPE_CODE_W-1:0] v);
    return (v != 16'h0000) && ((v & (v - 16'h0001)) == 16'h0000);
  endfunction

  // read multiplexer; unmapped and write-only offsets read as zero
  function automatic logic [31:0] npe_read_mux(input npe_state_t s,
                                               input logic [NPE_OFS_W-1:0] ofs);
    logic [31:0] r;
    r = 32'h0000_0000;
    case (ofs)
      NPE_OFS_MODE:     r[NPE_SEL_W-1:0]  = s.page_sel;
      NPE_OFS_STATUS:   r[NPE_ST_W-1:0]   = s.status;
      NPE_OFS_PARITY:   r[NPE_LOC_W-1:0]  = s.parity;
      NPE_OFS_NPARITY:  r[NPE_CODE_W-1:0] = s.nparity;
      NPE_OFS_IRQ_STAT: r[NPE_IRQ_W-1:0]  = s.irq_stat;
      NPE_OFS_IRQ_EN:   r[NPE_IRQ_W-1:0]  = s.irq_en;
      default:          r = 32'h0000_0000;
    endcase
    return r;
  endfunction

  // flash side decode; only whole code bits for this geometry take part
  assign code_mask  = npe_code_mask(st_r.page_sel, i_nf_wide);
  assign acc_p_nxt  = st_r.acc_p ^ word_p;
  assign acc_n_nxt  = st_r.acc_n ^ word_n;
  assign main_last  = st_r.word_cnt == npe_last_word(st_r.page_sel);
  assign spare_last = i_nf_wide ? (st_r.spare_cnt == NPE_SPARE_LAST_WIDE)
                                : (st_r.spare_cnt == NPE_SPARE_LAST_NARROW);
  assign is_start   = i_nf.cmd_valid &&
                      ((i_nf.data[7:0] == NPE_CMD_READ) ||
                       (i_nf.data[7:0] == NPE_CMD_PROG));

  // bus side decode; a write commits in its zero-wait data phase
  assign take     = i_hsel && i_htrans[1] && i_hready;
  assign bus_wr   = st_r.ph_valid && st_r.ph_write && st_r.ph_hit;
  assign sw_reset = bus_wr && (st_r.ph_ofs == NPE_OFS_CTRL) && i_hwdata[NPE_CTRL_SWRST];

  // next state of the whole block
  always_comb begin
    logic [31:0]           stored_nxt;
    logic [NPE_CODE_W-1:0] syn_p;
    logic [NPE_CODE_W-1:0] syn_n;
    stored_nxt = st_r.stored;
    syn_p      = 16'h0000;
    syn_n      = 16'h0000;
    irq_set    = NPE_IRQ_RST;
    st_nxt     = st_r;

    // address phase capture; a read then spends one wait cycle fetching data
    if (i_hready) begin
      st_nxt.ph_valid = take;
      st_nxt.ph_write = i_hwrite;
      st_nxt.ph_hit   = i_hsize == NPE_HSIZE_WORD;
      st_nxt.ph_ofs   = i_haddr[NPE_OFS_W-1:0];
      st_nxt.rd_wait  = 1'b0;
    end
    // registered read data avoids a combinational path from haddr to hrdata
    if (st_r.ph_valid && !st_r.ph_write && !st_r.rd_wait) begin
      st_nxt.rd_wait = 1'b1;
      st_nxt.hrdata  = st_r.ph_hit ? npe_read_mux(st_r, st_r.ph_ofs) : 32'h0000_0000;
    end

    // register writes
    if (bus_wr) begin
      case (st_r.ph_ofs)
        NPE_OFS_MODE:   st_nxt.page_sel = i_hwdata[NPE_MODE_SEL_LSB +: NPE_SEL_W];
        NPE_OFS_IRQ_EN: st_nxt.irq_en   = i_hwdata[NPE_IRQ_W-1:0];
        default:        st_nxt.page_sel = st_r.page_sel;
      endcase
    end

    // page walker
    if (sw_reset || is_start) begin
      // new page or software reset: drop everything of the last page
      st_nxt.status    = '0;
      st_nxt.parity    = '0;
      st_nxt.nparity   = '0;
      st_nxt.acc_p     = '0;
      st_nxt.acc_n     = '0;
      st_nxt.word_cnt  = '0;
      st_nxt.spare_cnt = '0;
      st_nxt.stored    = '0;
      st_nxt.is_read   = i_nf.data[7:0] == NPE_CMD_READ;
      st_nxt.fsm       = sw_reset ? NPE_IDLE : NPE_ARM;
    end else begin
      case (st_r.fsm)
        NPE_IDLE: begin
          st_nxt.fsm = NPE_IDLE;  // results stay locked here
        end
        NPE_ARM: begin
          if (i_nf.addr_valid) begin
            st_nxt.fsm = NPE_ADDR;
          end
        end
        NPE_ADDR, NPE_DATA: begin
          // confirm commands such as a large-page read do not disturb the count
          if (i_nf.data_valid) begin
            st_nxt.fsm      = NPE_DATA;
            st_nxt.acc_p    = acc_p_nxt;
            st_nxt.acc_n    = acc_n_nxt;
            st_nxt.word_cnt = st_r.word_cnt + 13'h0001;
            if (main_last) begin
              // computed code valid and frozen from here on; on a read the spare check may still load parity with the error location
              st_nxt.acc_p   = acc_p_nxt & code_mask;
              st_nxt.acc_n   = acc_n_nxt & code_mask;
              st_nxt.parity  = {1'b0, acc_p_nxt & code_mask};
              st_nxt.nparity = acc_n_nxt & code_mask;
              st_nxt.fsm     = st_r.is_read ? NPE_SPARE : NPE_IDLE;
              irq_set[NPE_IRQ_DONE] = 1'b1;
            end
          end
        end
        NPE_SPARE: begin
          // stored code follows the main area: parity low half first, then inverse
          if (i_nf.data_valid) begin
            if (i_nf_wide) begin
              stored_nxt[{st_r.spare_cnt[0], 4'h0} +: NPE_DAT_W] = i_nf.data;
            end else begin
              stored_nxt[{st_r.spare_cnt, 3'h0} +: 8] = i_nf.data[7:0];
            end
            st_nxt.stored    = stored_nxt;
            st_nxt.spare_cnt = st_r.spare_cnt + 2'h1;
            if (spare_last) begin
              syn_p = (st_r.acc_p ^ stored_nxt[NPE_CODE_W-1:0]) & code_mask;
              syn_n = (st_r.acc_n ^ stored_nxt[31:NPE_CODE_W]) & code_mask;
              st_nxt.fsm = NPE_IDLE;
              if ((syn_p == 16'h0000) && (syn_n == 16'h0000)) begin
                st_nxt.status = '0;
              end else if ((syn_p ^ syn_n) == code_mask) begin
                // one data bit flipped: the parity syndrome is its address
                st_nxt.status[NPE_ST_CORR] = 1'b1;
                st_nxt.parity = i_nf_wide ? {1'b0, syn_p}
                                          : {syn_p[15:3], 1'b0, syn_p[2:0]};
                irq_set[NPE_IRQ_ERR] = 1'b1;
              end else if (npe_one_hot(syn_p | syn_n) && ((syn_p & syn_n) == 16'h0000)) begin
                // exactly one bit over both halves; two data flips give equal halves instead
                st_nxt.status[NPE_ST_CODE] = 1'b1;
                irq_set[NPE_IRQ_ERR] = 1'b1;
              end else begin
                st_nxt.status[NPE_ST_MULT] = 1'b1;
                irq_set[NPE_IRQ_ERR] = 1'b1;
              end
            end
          end
        end
        default: begin
          st_nxt.fsm = NPE_IDLE;
        end
      endcase
    end

    // sticky interrupt status; an event in the clearing cycle survives the clear
    if (bus_wr && (st_r.ph_ofs == NPE_OFS_IRQ_CLR)) begin
      st_nxt.irq_stat = (st_r.irq_stat & ~i_hwdata[NPE_IRQ_W-1:0]) | irq_set;
    end else begin
      st_nxt.irq_stat = st_r.irq_stat | irq_set;
    end
  end

  // single state register of the block
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      st_r          <= '0;
      st_r.page_sel <= NPE_MODE_RST;
      st_r.irq_stat <= NPE_IRQ_RST;
      st_r.irq_en   <= NPE_IRQ_RST;
      st_r.fsm      <= NPE_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // bus answer: reads insert one wait state, writes none, always okay
  assign o_hreadyout = !(st_r.ph_valid && !st_r.ph_write && !st_r.rd_wait);
  assign o_hresp     = NPE_HRESP_OKAY;
  assign o_hrdata    = st_r.hrdata;
  // level interrupt while an enabled status bit is set
  assign o_irq       = |(st_r.irq_stat & st_r.irq_en);

endmodule // npe_engine
`default_nettype wire

// ### src/npe_pkg.sv
// shared constants, types and helpers of the nand page ecc engine
`default_nettype none
package npe_pkg;
  // register byte offsets on the ahb-lite slave
  localparam logic [7:0] NPE_OFS_MODE     = 8'h00;
  localparam logic [7:0] NPE_OFS_CTRL     = 8'h04;
  localparam logic [7:0] NPE_OFS_STATUS   = 8'h08;
  localparam logic [7:0] NPE_OFS_PARITY   = 8'h0c;
  localparam logic [7:0] NPE_OFS_NPARITY  = 8'h10;
  localparam logic [7:0] NPE_OFS_IRQ_STAT = 8'h14;
  localparam logic [7:0] NPE_OFS_IRQ_CLR  = 8'h18;
  localparam logic [7:0] NPE_OFS_IRQ_EN   = 8'h1c;
  localparam int         NPE_OFS_W        = 8;
  // ahb-lite encodings
  localparam logic [2:0] NPE_HSIZE_WORD   = 3'h2;
  localparam logic       NPE_HRESP_OKAY   = 1'b0;
  // flash commands that open a computation
  localparam logic [7:0] NPE_CMD_READ     = 8'h00;
  localparam logic [7:0] NPE_CMD_PROG     = 8'h80;
  // widths
  localparam int NPE_SEL_W  = 2;
  localparam int NPE_CODE_W = 16;
  localparam int NPE_WORD_W = 13;
  localparam int NPE_LOC_W  = 17;
  localparam int NPE_DAT_W  = 16;
  localparam int NPE_ST_W   = 3;
  localparam int NPE_IRQ_W  = 2;
  // field positions
  localparam int NPE_MODE_SEL_LSB = 0;
  localparam int NPE_CTRL_SWRST   = 0;
  localparam int NPE_ST_CORR      = 0;
  localparam int NPE_ST_CODE      = 1;
  localparam int NPE_ST_MULT      = 2;
  localparam int NPE_IRQ_DONE     = 0;
  localparam int NPE_IRQ_ERR      = 1;
  // reset values
  localparam logic [NPE_SEL_W-1:0] NPE_MODE_RST = 2'h0;
  localparam logic [NPE_IRQ_W-1:0] NPE_IRQ_RST  = 2'h0;
  // main area is 512 words at the smallest page, doubling per select step
  localparam logic [NPE_WORD_W-1:0] NPE_MAIN_BASE = 13'h0200;
  localparam logic [4:0] NPE_ADDR_BITS_BASE = 5'h0c;  // 9 line bits + 3 column bits
  localparam logic [1:0] NPE_SPARE_LAST_WIDE   = 2'h1;
  localparam logic [1:0] NPE_SPARE_LAST_NARROW = 2'h3;

  // snooped external flash bus cycles, same clock as the engine
  typedef struct packed {
    logic                 cmd_valid;
    logic                 addr_valid;
    logic                 data_valid;
    logic [NPE_DAT_W-1:0] data;
  } npe_nf_t;

  typedef enum logic [2:0] {NPE_IDLE, NPE_ARM, NPE_ADDR, NPE_DATA, NPE_SPARE} npe_fsm_t;

  // bits of the code that carry meaning for this page size and word width
  function automatic logic [NPE_CODE_W-1:0] npe_code_mask(input logic [NPE_SEL_W-1:0] sel,
                                                          input logic wide);
    logic [4:0] nbits;
    nbits = NPE_ADDR_BITS_BASE + {3'h0, sel} + {4'h0, wide};
    return 16'hffff >> (5'h10 - nbits);
  endfunction

  function automatic logic [NPE_WORD_W-1:0] npe_last_word(input logic [NPE_SEL_W-1:0] sel);
    return (NPE_MAIN_BASE << sel) - 13'h0001;
  endfunction
endpackage : npe_pkg
`default_nettype wire

// ### src/npe_word_parity.sv
// parity contribution of one flash word to the line and column code
`default_nettype none
module npe_word_parity import npe_pkg::*; (
  input  wire logic [NPE_DAT_W-1:0]  i_data,
  input  wire logic [NPE_WORD_W-1:0] i_word,
  input  wire logic                  i_wide,
  output logic      [NPE_CODE_W-1:0] o_par,
  output logic      [NPE_CODE_W-1:0] o_npar
);
  // bit address of data bit b in word w: line bits above, column bits below
  function automatic logic [NPE_CODE_W-1:0] npe_bit_addr(input logic [NPE_WORD_W-1:0] w,
                                                         input logic [3:0] b,
                                                         input logic wide);
    return wide ? {w[11:0], b} : {w, b[2:0]};
  endfunction

  wire logic [NPE_DAT_W-1:0]  dval;
  wire logic [NPE_CODE_W-1:0] addr_tab [NPE_DAT_W];
  wire logic [NPE_DAT_W-1:0]  tap      [NPE_CODE_W];

  // upper byte only counts on 16-bit flash
  for (genvar b = 0; b < NPE_DAT_W; b++) begin : g_bit
    assign dval[b]     = i_data[b] & (i_wide | (b < 8));
    assign addr_tab[b] = npe_bit_addr(i_word, 4'(b), i_wide);
    for (genvar k = 0; k < NPE_CODE_W; k++) begin : g_tap
      assign tap[k][b] = addr_tab[b][k];
    end
  end

  // even parity over bits whose address bit is one, inverse over bits where it is zero
  for (genvar k = 0; k < NPE_CODE_W; k++) begin : g_code
    assign o_par[k]  = ^(dval & tap[k]);
    assign o_npar[k] = ^(dval & ~tap[k]);
  end
endmodule // npe_word_parity
`default_nettype wire

// ### bench/npe_engine_monitor.sv
// port-level assertions and covers for the nand page ecc engine
`default_nettype none
module npe_engine_monitor import npe_pkg::*; (
  input wire logic        i_core_clk,
  input wire logic        i_nrst,
  input wire logic        i_hsel,
  input wire logic [1:0]  i_htrans,
  input wire logic        i_hwrite,
  input wire logic        i_hready,
  input wire logic        o_hreadyout,
  input wire logic        o_hresp,
  input wire logic [31:0] o_hrdata,
  input wire npe_nf_t     i_nf,
  input wire logic        o_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic rd_take;
  logic wr_take;
  // address phases the slave accepts
  assign rd_take = i_hsel & i_htrans[1] & i_hready & ~i_hwrite;
  assign wr_take = i_hsel & i_htrans[1] & i_hready & i_hwrite;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);
  a_resp_okay: assert property (o_hresp == NPE_HRESP_OKAY) else $error("bad response");
  a_read_wait: assert property (rd_take |=> !o_hreadyout ##1 o_hreadyout)
    else $error("read wait state wrong");
  a_write_nowait: assert property (wr_take |=> o_hreadyout)
    else $error("write stalled");
  a_wait_cause: assert property ($fell(o_hreadyout) |-> $past(rd_take))
    else $error("stall without read");
  // read data only moves two edges after an accepted read, or out of reset
  a_rdata_hold: assert property ($changed(o_hrdata) |->
    $past(rd_take, 2) || !$past(i_nrst)) else $error("read data moved alone");
  a_irq_cause: assert property ($rose(o_irq) |->
    $past(i_nf.data_valid) || $past(wr_take, 2)) else $error("interrupt rose alone");
  a_irq_sticky: assert property ($fell(o_irq) |-> $past(wr_take, 2) || !$past(i_nrst))
    else $error("interrupt fell alone");
  // the reset level itself is checked, so this one is never disabled
  a_reset_idle: assert property (disable iff (1'b0) !i_nrst |=> o_hreadyout && !o_irq)
    else $error("busy out of reset");
  c_read: cover property (rd_take);
  c_irq: cover property ($rose(o_irq));
  c_start: cover property (i_nf.cmd_valid && i_nf.data[7:0] == NPE_CMD_READ);
endmodule // npe_engine_monitor
bind npe_engine npe_engine_monitor i_npe_engine_monitor (.i_core_clk(i_core_clk),
  .i_nrst(i_nrst), .i_hsel(i_hsel), .i_htrans(i_htrans), .i_hwrite(i_hwrite),
  .i_hready(i_hready), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .o_hrdata(o_hrdata),
  .i_nf(i_nf), .o_irq(o_irq));
`default_nettype wire

// ### bench/npe_flash_model.sv
// behavioural flash page source on the snooped external bus
`default_nettype none
module npe_flash_model import npe_pkg::*; (
  input  wire logic        i_core_clk,
  input  wire logic        i_go,
  input  wire logic [7:0]  i_cmd,
  input  wire logic [12:0] i_words,
  input  wire logic        i_wide,
  input  wire logic [3:0]  i_gap,
  input  wire logic [31:0] i_code,
  input  wire logic [16:0] i_flip_a,
  input  wire logic [16:0] i_flip_b,
  output npe_nf_t          o_nf,
  output logic             o_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] last = 16'h0;
  // page content is a fixed scramble of the word offset
  function automatic logic [15:0] word_at(input int i, input logic w);
    logic [15:0] v;
    v = 16'(i * 40503) ^ 16'(i >> 5);
    return w ? v : {8'h00, v[7:0]};
  endfunction
  // bit to flip in word i for an error location {word, bit}
  function automatic logic [15:0] flip(input int i, input logic [16:0] loc);
    return (loc[16:4] == 13'(i)) ? 16'h1 << loc[3:0] : 16'h0;
  endfunction
  // one cycle after i_gap idle ones; idle data shows the inverted last value, never a stale one
  task automatic emit(input logic [2:0] kind, input logic [15:0] v);
    repeat (i_gap) begin
      o_nf <= {3'b000, ~last};
      @(posedge i_core_clk);
    end
    o_nf <= {kind, v};
    last = v;
    @(posedge i_core_clk);
  endtask
  // command, page-start address, main area, then the stored code on reads
  initial begin
    o_nf = '0;
    o_busy = 1'b0;
    forever begin
      @(posedge i_core_clk);
      if (i_go) begin
        o_busy <= 1'b1;
        emit(3'b100, {8'h00, i_cmd});
        repeat (3) emit(3'b010, 16'h0000);
        if (i_cmd == NPE_CMD_READ) emit(3'b100, 16'h0030);
        for (int i = 0; i < int'(i_words); i++)
          emit(3'b001, word_at(i, i_wide) ^ flip(i, i_flip_a) ^ flip(i, i_flip_b));
        for (int k = 0; k < 4 && i_cmd == NPE_CMD_READ; k++)
          if (!i_wide || k < 2)
            emit(3'b001, i_wide ? i_code[k*16 +: 16] : {8'h00, i_code[k*8 +: 8]});
        o_nf <= {3'b000, ~last};
        o_busy <= 1'b0;
      end
    end
  end
endmodule // npe_flash_model
`default_nettype wire

// ### bench/npe_engine_bench.sv
// self-checking bench for the nand page ecc engine
`default_nettype none
module npe_engine_bench import npe_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, hready, busy, irq;
  logic        nrst = 1'b0, hsel = 1'b0, hwrite = 1'b0, go = 1'b0, wide = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, code = 32'h0;
  logic [7:0]  cmd = 8'h00;
  logic [12:0] words = 13'h0000;
  logic [3:0]  gap = 4'h0;
  logic [16:0] fa = 17'h1ffff, fb = 17'h1ffff;
  npe_nf_t     nf;
  int          n_errors = 0, cmp_count = 0;
  // read cases: data flips, stored code flip, expected status
  // last case: two flips in one word whose bit addresses differ in a single bit
  logic [16:0] tfa [5] = '{17'h012c5, 17'h012c5, 17'h1ffff, 17'h1ffff, 17'h012c5};
  logic [16:0] tfb [5] = '{17'h1ffff, 17'h00112, 17'h1ffff, 17'h1ffff, 17'h012c4};
  logic [31:0] tcf [5] = '{32'h0, 32'h0, 32'h0, 32'h8, 32'h0};
  logic [31:0] tst [5] = '{32'h1, 32'h4, 32'h0, 32'h2, 32'h4};
  npe_engine i_npe_engine (.i_core_clk(clk), .i_nrst(nrst), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(NPE_HSIZE_WORD), .i_hwdata(hwdata),
    .i_hready(hready), .o_hreadyout(hready), .o_hresp(), .o_hrdata(hrdata), .i_nf(nf),
    .i_nf_wide(wide), .o_irq(irq));
  npe_flash_model i_npe_flash_model (.i_core_clk(clk), .i_go(go), .i_cmd(cmd), .i_words(words),
    .i_wide(wide), .i_gap(gap), .i_code(code), .i_flip_a(fa), .i_flip_b(fb), .o_nf(nf),
    .o_busy(busy));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // an expired wait counts as a mismatch and ends the run
  task automatic hang();
    n_errors++;
    finish_test();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // hready is looked at just before the edge, where it has settled
  task automatic rdy(output logic [31:0] d);
    int n;
    for (n = 0; n < 16; n++) begin
      @(negedge clk);
      d = hrdata;
      if (hready === 1'b1) break;
      @(posedge clk);
    end
    if (n == 16) hang();
    @(posedge clk);
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    rdy(rd);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    rdy(rd);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] d;
    bus(1'b1, a, v, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    bus(1'b0, a, 32'h0, d);
    chk(d, exp);
  endtask
  task automatic irq_chk(input logic e);
    @(negedge clk);
    chk({31'h0, irq}, {31'h0, e});
  endtask
  // one flash page through the model, waited for under a bound
  task automatic page(input logic [7:0] c, input int n, input logic w, input logic [31:0] sc,
                      input logic [3:0] g, input logic [16:0] a, input logic [16:0] b);
    int k;
    @(posedge clk);
    cmd <= c;
    words <= 13'(n);
    wide <= w;
    code <= sc;
    gap <= g;
    fa <= a;
    fb <= b;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    for (k = 0; k < 20000; k++) begin
      @(negedge clk);
      if (busy === 1'b0) break;
    end
    if (k == 20000) hang();
  endtask
  // expected code {np, p}: p[k] xors data bits whose bit address has bit k set, np the rest
  function automatic logic [31:0] code_of(input int n, input logic w, input logic [1:0] s);
    logic [16:0] a;
    logic [15:0] p, q, d, m;
    p = 16'h0;
    q = 16'h0;
    m = 16'((32'h1 << (12 + s + w)) - 1);
    for (int i = 0; i < n; i++) begin
      d = i_npe_flash_model.word_at(i, w);
      for (int b = 0; b < (w ? 16 : 8); b++) begin
        a = w ? {i[12:0], b[3:0]} : {1'b0, i[12:0], b[2:0]};
        if (d[b]) p ^= a[15:0];
        if (d[b]) q ^= ~a[15:0];
      end
    end
    return {q & m, p & m};
  endfunction
  initial begin
    logic [31:0] c;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    rdc(NPE_OFS_MODE, 32'h0);
    rdc(NPE_OFS_STATUS, 32'h0);
    rdc(NPE_OFS_IRQ_STAT, 32'h0);
    rdc(8'h20, 32'h0);
    $display("reset test done");
    wr(NPE_OFS_IRQ_EN, 32'h1);
    // every page size; words past the main area must not move the locked code
    for (int s = 0; s < 4; s++) begin
      wr(NPE_OFS_MODE, 32'(s));
      rdc(NPE_OFS_MODE, 32'(s));
      page(NPE_CMD_PROG, (512 << s) + 5, 1'b0, 32'h0, 4'(s == 0), 17'h1ffff, 17'h1ffff);
      c = code_of(512 << s, 1'b0, 2'(s));
      rdc(NPE_OFS_PARITY, {16'h0, c[15:0]});
      rdc(NPE_OFS_NPARITY, {16'h0, c[31:16]});
      irq_chk(1'b1);
      wr(NPE_OFS_IRQ_CLR, 32'h1);
      irq_chk(1'b0);
    end
    $display("page size test done");
    wr(NPE_OFS_MODE, 32'h0);
    page(NPE_CMD_PROG, 512, 1'b1, 32'h0, 4'h0, 17'h1ffff, 17'h1ffff);
    c = code_of(512, 1'b1, 2'h0);
    rdc(NPE_OFS_PARITY, {16'h0, c[15:0]});
    rdc(NPE_OFS_NPARITY, {16'h0, c[31:16]});
    $display("wide page test done");
    c = code_of(512, 1'b0, 2'h0);
    for (int k = 0; k < 5; k++) begin
      page(NPE_CMD_READ, 512, 1'b0, c ^ tcf[k], 4'h0, tfa[k], tfb[k]);
      rdc(NPE_OFS_STATUS, tst[k]);
      if (k == 0) rdc(NPE_OFS_PARITY, 32'h12c5);
      rdc(NPE_OFS_IRQ_STAT, (tst[k] != 32'h0) ? 32'h3 : 32'h1);
      wr(NPE_OFS_IRQ_CLR, 32'h3);
    end
    // 16-bit page: stored code comes as two words and the bit field is four bits wide
    page(NPE_CMD_READ, 512, 1'b1, code_of(512, 1'b1, 2'h0), 4'h0,
         17'h012cc, 17'h1ffff);
    rdc(NPE_OFS_STATUS, 32'h1);
    rdc(NPE_OFS_PARITY, 32'h12cc);
    rdc(NPE_OFS_IRQ_STAT, 32'h3);
    wr(NPE_OFS_IRQ_CLR, 32'h3);
    $display("read check test done");
    wr(NPE_OFS_CTRL, 32'h1);
    rdc(NPE_OFS_STATUS, 32'h0);
    rdc(NPE_OFS_PARITY, 32'h0);
    rdc(NPE_OFS_NPARITY, 32'h0);
    rdc(NPE_OFS_IRQ_EN, 32'h1);
    $display("software reset test done");
    finish_test();
  end
endmodule // npe_engine_bench
`default_nettype wire
